// File: rtl/eli_map.vh
// constants for the error lamp indicator
`ifndef ELI_MAP_VH
`define ELI_MAP_VH
// ---------------------------------------------------------------
// error classes on the event input
// ---------------------------------------------------------------
`define ELI_CLASS_SYSTEM   1'b0
`define ELI_CLASS_PROTOCOL 1'b1
// ---------------------------------------------------------------
// system error codes, serious range and reserved codes
// ---------------------------------------------------------------
`define ELI_SYS_HW_FAULT   4'h1
`define ELI_SYS_NVM_ERR    4'h2
`define ELI_SYS_INT_MEM    4'h3
`define ELI_SYS_BUS_HW     4'h4
`define ELI_SYS_SCRIPT     4'h5
`define ELI_SYS_TX_OVF     4'h7
`define ELI_SYS_RX_OVF     4'h8
`define ELI_SYS_TIMEOUT    4'h9
`define ELI_SYS_BUS_GEN    4'ha
`define ELI_SYS_PARITY     4'hb
`define ELI_SYS_BUS_CFG    4'hd
`define ELI_SYS_BUS_OVF    4'he
`define ELI_SYS_RSV0       4'h0
`define ELI_SYS_RSV6       4'h6
`define ELI_SYS_RSV12      4'hc
`define ELI_SYS_RSV15      4'hf
`define ELI_SERIOUS_MAX    4'h5
// ---------------------------------------------------------------
// protocol error codes
// ---------------------------------------------------------------
`define ELI_PRO_NO_SCRIPT  4'h3
`define ELI_PRO_UNKNOWN    4'h5
`define ELI_PRO_TIMEOUT    4'h9
`define ELI_PRO_CHECKSUM   4'hb
`define ELI_PRO_FUNC_CODE  4'hc
`define ELI_PRO_EXCEPTION  4'he
`define ELI_PRO_INTERNAL   4'hf
// ---------------------------------------------------------------
// timing: clock rate, flash rates, warning hold
// ---------------------------------------------------------------
`define ELI_CLK_HZ         200000000
`define ELI_SYS_FLASH_HZ   2
`define ELI_PRO_FLASH_HZ   1
`define ELI_WARN_HOLD_S    60
// hold timer width: a minute of cycles at full clock needs 34 bits
`define ELI_HOLD_W         36
`endif

// File: rtl/eli_tick_gen.v
// free-running divider giving a one-cycle tick every PERIOD cycles
module eli_tick_gen #(
  parameter WIDTH  = 32,
  parameter PERIOD = 100
) (
  input  wire clk,
  input  wire nrst,
  input  wire clr,
  output reg  tick
);
  reg [WIDTH-1:0] cnt_reg;

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  // count up, wrap at period, restart on clear
  always @(posedge clk) begin
    if (!nrst || clr) begin
      cnt_reg <= {WIDTH{1'b0}};
      tick    <= 1'b0;
    end else if (cnt_reg == PERIOD[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1}) begin
      cnt_reg <= {WIDTH{1'b0}};
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      tick    <= 1'b0;
    end
  end
endmodule

// File: rtl/eli_error_lamps.v
// error indicator: red state request and four flashing binary lamps
`include "eli_map.vh"

// Functional notes
// - any error: state red, number on lamps
// - binary on four lamps, flashing, red steady
// - system codes 1-5 serious, latched until power cycle
// - system codes 7-14 shown one minute
// - config mode pattern carries no meaning
// - serious system codes one to five
// - warning system codes seven to fourteen
// - system errors flash twice per second
// - protocol errors flash once per second
// - protocol errors held for warning time
// - protocol codes 3 and 5, all protocols
// - modbus master timeout gives code 9
// - checksum mismatch gives protocol code 11
// - code 12 function code or encoder
// - code 14 exception, 15 measurement/reception
module eli_error_lamps #(
  parameter CLK_HZ      = `ELI_CLK_HZ,
  parameter [`ELI_HOLD_W-1:0] WARN_CYCLES = {`ELI_HOLD_W{1'b0}} + `ELI_WARN_HOLD_S * `ELI_CLK_HZ,
  parameter SYS_HALF    = `ELI_CLK_HZ / (2 * `ELI_SYS_FLASH_HZ),
  parameter PRO_HALF    = `ELI_CLK_HZ / (2 * `ELI_PRO_FLASH_HZ)
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire        errValid,
  input  wire        errClass,
  input  wire [3:0]  errCode,
  input  wire        configMode,
  input  wire [31:0] warnTimeCycles,
  output reg         stateRed,
  output reg         error_bit3_lamp,
  output reg         error_bit2_lamp,
  output reg         error_bit1_lamp,
  output reg         error_bit0_lamp,
  output reg         patternValid
);
  // display states and hold timer constants
  localparam              ST_IDLE    = 2'b00;
  localparam              ST_WARN    = 2'b01;
  localparam              ST_SERIOUS = 2'b10;
  localparam              HOLD_W     = `ELI_HOLD_W;
  localparam [HOLD_W-1:0] HOLD_ONE   = {{(HOLD_W-1){1'b0}}, 1'b1};
  localparam [HOLD_W-1:0] HOLD_ZERO  = {HOLD_W{1'b0}};

  reg  [1:0]        state_reg;
  reg  [1:0]        state_next;
  reg  [3:0]        code_reg;
  reg               class_reg;
  reg  [HOLD_W-1:0] hold_reg;
  reg  [HOLD_W-1:0] hold_next;
  reg  [HOLD_W-1:0] holdLoad;
  reg               phase_reg;
  reg               accept;
  reg               isSerious;
  reg               isReserved;
  wire              showing;
  wire              sysTick;
  wire              proTick;
  wire              flashTick;

  // ------------------------------------------------------------
  // flash rate dividers
  // ------------------------------------------------------------
  // half-period ticks for two and one flashes per second
  eli_tick_gen #(.WIDTH(32), .PERIOD(SYS_HALF)) uSysTick (
    .clk  (clk),
    .nrst (nrst),
    .clr  (accept),
    .tick (sysTick)
  );
  eli_tick_gen #(.WIDTH(32), .PERIOD(PRO_HALF)) uProTick (
    .clk  (clk),
    .nrst (nrst),
    .clr  (accept),
    .tick (proTick)
  );
  assign flashTick = (class_reg == `ELI_CLASS_SYSTEM) ? sysTick : proTick;

  // ------------------------------------------------------------
  // display flag
  // ------------------------------------------------------------
  // a code is on show in either non-idle state
  assign showing = (state_reg != ST_IDLE);

  // ------------------------------------------------------------
  // event qualification
  // ------------------------------------------------------------
  // reserved system codes are dropped, never shown
  always @* begin
    case (errCode)
      `ELI_SYS_RSV0,
      `ELI_SYS_RSV6,
      `ELI_SYS_RSV12,
      `ELI_SYS_RSV15: begin
        isReserved = (errClass == `ELI_CLASS_SYSTEM);
      end
      default: begin
        isReserved = 1'b0;
      end
    endcase
  end

  // classify serious codes, refuse everything once latched
  always @* begin
    isSerious = (errClass == `ELI_CLASS_SYSTEM) && !isReserved
                && (errCode <= `ELI_SERIOUS_MAX);
    accept = errValid && !isReserved;
    if (state_reg == ST_SERIOUS) begin
      accept = 1'b0; // serious display stays until power cycle
    end
  end

  // ------------------------------------------------------------
  // hold time selection
  // ------------------------------------------------------------
  // protocol errors take the live setting, zero stretched to one cycle
  always @* begin
    if (errClass == `ELI_CLASS_PROTOCOL) begin
      if (warnTimeCycles == 32'h0) begin
        holdLoad = HOLD_ONE;
      end else begin
        holdLoad = {{(HOLD_W-32){1'b0}}, warnTimeCycles};
      end
    end else begin
      holdLoad = WARN_CYCLES;
    end
  end

  // ------------------------------------------------------------
  // display state machine
  // ------------------------------------------------------------
  // next state and hold timer
  always @* begin
    state_next = state_reg;
    hold_next  = hold_reg;
    case (state_reg)
      ST_IDLE,
      ST_WARN: begin
        if (accept) begin
          if (isSerious) begin
            state_next = ST_SERIOUS;
          end else begin
            state_next = ST_WARN;
            hold_next  = holdLoad;
          end
        end else if (state_reg == ST_WARN) begin
          if (hold_reg <= HOLD_ONE) begin
            state_next = ST_IDLE;
            hold_next  = HOLD_ZERO;
          end else begin
            hold_next = hold_reg - HOLD_ONE;
          end
        end
      end
      ST_SERIOUS: begin
        state_next = ST_SERIOUS;
      end
      default: begin
        state_next = ST_IDLE;
        hold_next  = HOLD_ZERO;
      end
    endcase
  end

  // state, hold timer and latched code
  always @(posedge clk) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      hold_reg  <= HOLD_ZERO;
      code_reg  <= 4'h0;
      class_reg <= `ELI_CLASS_SYSTEM;
    end else begin
      state_reg <= state_next;
      hold_reg  <= hold_next;
      if (accept) begin
        code_reg  <= errCode;
        class_reg <= errClass;
      end
    end
  end

  // flash phase, restarted lit on every accepted event
  always @(posedge clk) begin
    if (!nrst) begin
      phase_reg <= 1'b0;
    end else if (accept) begin
      phase_reg <= 1'b1; // lamps start lit
    end else if (flashTick) begin
      phase_reg <= ~phase_reg;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // registered lamp drive
  always @(posedge clk) begin
    if (!nrst) begin
      stateRed        <= 1'b0;
      error_bit3_lamp <= 1'b0;
      error_bit2_lamp <= 1'b0;
      error_bit1_lamp <= 1'b0;
      error_bit0_lamp <= 1'b0;
      patternValid    <= 1'b0;
    end else begin
      stateRed        <= showing;
      error_bit3_lamp <= showing && phase_reg && code_reg[3];
      error_bit2_lamp <= showing && phase_reg && code_reg[2];
      error_bit1_lamp <= showing && phase_reg && code_reg[1];
      error_bit0_lamp <= showing && phase_reg && code_reg[0];
      patternValid    <= showing && !configMode;
    end
  end
endmodule

// File: bench/eli_error_lamps_assertions.sv
// port assertions for the error lamp indicator
module eli_lamp_assertions #(parameter WARN_CYCLES = 1000) (
  input logic        clk,
  input logic        nrst,
  input logic        errValid,
  input logic        errClass,
  input logic [3:0]  errCode,
  input logic        configMode,
  input logic [31:0] warnTimeCycles,
  input logic        stateRed,
  input logic        error_bit3_lamp,
  input logic        error_bit2_lamp,
  input logic        error_bit1_lamp,
  input logic        error_bit0_lamp,
  input logic        patternValid
);
  timeunit 1ns / 1ps;
  wire [3:0]   lamp = {error_bit3_lamp, error_bit2_lamp, error_bit1_lamp, error_bit0_lamp};
  wire         rsv = errCode inside {4'h0, 4'h6, 4'hc, 4'hf};
  wire         take = errValid && (errClass || !rsv);
  logic        latch;
  logic [15:0] quiet;
  // serious latch and cycles since the last event
  always_ff @(posedge clk) begin
    latch <= nrst && (latch || take && !errClass && errCode <= 4'h5);
    quiet <= (!nrst || errValid) ? 16'h0 : quiet + {15'h0, quiet != 16'hffff};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_event_red: assert property (take |-> ##2 stateRed) else $error("no red");
  a_event_code: assert property (take && !latch |-> ##2 lamp == $past(errCode, 2))
    else $error("wrong lamps");
  a_lamps_red: assert property (lamp != 4'h0 |-> stateRed) else $error("lamp, no red");
  a_rsv_drop: assert property (errValid && rsv && !errClass && !stateRed
    && !$past(errValid) ##1 !errValid |=> !stateRed) else $error("reserved shown");
  a_serious_hold: assert property (latch |-> ##2 stateRed) else $error("serious lost");
  a_config_mute: assert property (configMode [*3] |-> !patternValid) else $error("cfg");
  a_idle_quiet: assert property (!stateRed && !errValid && !$past(errValid) |=> !stateRed)
    else $error("red without event");
  a_warn_expire: assert property (quiet == WARN_CYCLES + 4 && !latch
    && warnTimeCycles <= WARN_CYCLES |-> !stateRed) else $error("warning held too long");
endmodule
bind eli_error_lamps eli_lamp_assertions #(.WARN_CYCLES(WARN_CYCLES)) u_lampChk (
  .clk(clk), .nrst(nrst), .errValid(errValid), .errClass(errClass), .errCode(errCode),
  .configMode(configMode), .warnTimeCycles(warnTimeCycles), .stateRed(stateRed),
  .error_bit3_lamp(error_bit3_lamp), .error_bit2_lamp(error_bit2_lamp),
  .error_bit1_lamp(error_bit1_lamp), .error_bit0_lamp(error_bit0_lamp),
  .patternValid(patternValid));

// File: bench/eli_lamp_observer.sv
// operator model: last lit pattern and length of each lit span
module eli_lamp_observer (
  input  logic        clk,
  input  logic [3:0]  lamp,
  output logic [3:0]  seenCode,
  output logic [15:0] litLen
);
  timeunit 1ns / 1ps;
  logic [15:0] run = 16'h0;
  // lamps weighted 8,4,2,1 read as one binary word
  always @(posedge clk) begin
    if (lamp != 4'h0) begin
      seenCode <= lamp;
      run <= run + 16'h1;
    end else begin
      if (run != 16'h0) litLen <= run;
      run <= 16'h0;
    end
  end
endmodule

// File: bench/tb_error_led_indicator.sv
// self-checking bench for the error lamp indicator
module tb_error_led_indicator;
  timeunit 1ns / 1ps;
  localparam int WARN = 1000;
  localparam int SHALF = 10;
  localparam int PHALF = 20;
  logic        clk = 1'b0, nrst = 1'b0, errValid = 1'b0, errClass = 1'b0, cfg = 1'b0;
  logic [3:0]  errCode = 4'h0, lamp, seenCode;
  logic        stateRed, patValid;
  logic [31:0] warnTime = 32'h12c;
  logic [15:0] litLen;
  int          errTotal = 0, totalChecks = 0;
  always #2.5 clk = ~clk;
  eli_error_lamps #(.WARN_CYCLES(WARN), .SYS_HALF(SHALF), .PRO_HALF(PHALF)) dut (
    .clk(clk), .nrst(nrst), .errValid(errValid), .errClass(errClass), .errCode(errCode),
    .configMode(cfg), .warnTimeCycles(warnTime), .stateRed(stateRed),
    .error_bit3_lamp(lamp[3]), .error_bit2_lamp(lamp[2]), .error_bit1_lamp(lamp[1]),
    .error_bit0_lamp(lamp[0]), .patternValid(patValid));
  eli_lamp_observer op (.clk(clk), .lamp(lamp), .seenCode(seenCode), .litLen(litLen));
  // compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset();
    nrst = 1'b0;
    wait_n(16);
    nrst = 1'b1;
  endtask
  // one-cycle event, returns once the lamps have answered
  task automatic raise(input logic cls, input logic [3:0] code);
    errClass = cls;
    errCode = code;
    errValid = 1'b1;
    wait_n(1);
    errValid = 1'b0;
    wait_n(2);
  endtask
  // codes shown in turn, then flash span and hold time of the last
  task automatic burst(input logic cls, input logic [3:0] codes[7], input int half, hold);
    warnTime = cls ? 32'(hold) : 32'h10;
    foreach (codes[i]) begin
      raise(cls, codes[i]);
      chk("lamps", {12'h0, codes[i]}, {12'h0, lamp});
      chk("valid", 16'h1, {15'h0, patValid});
    end
    wait_n(4 * half + 4);
    chk("lit span", half[15:0], litLen);
    wait_n(hold - 4 * half - 20);
    chk("held", 16'h1, {15'h0, stateRed});
    wait_n(28);
    chk("cleared", 16'h0, {11'h0, stateRed, lamp});
  endtask
  task automatic t_reserved();
    logic [3:0] rsv[4] = '{4'h0, 4'h6, 4'hc, 4'hf};
    foreach (rsv[i]) begin
      raise(1'b0, rsv[i]);
      chk("reserved", 16'h0, {15'h0, stateRed});
    end
  endtask
  // serious code replaces a warning, then outlives refusals and config mode
  task automatic t_serious();
    for (int c = 1; c <= 5; c++) begin
      do_reset();
      raise(1'b0, 4'h9);
      raise(1'b0, c[3:0]);
      chk("serious", c[15:0], {12'h0, lamp});
    end
    raise(1'b1, 4'h3);
    cfg = 1'b1;
    wait_n(WARN + 20);
    chk("latched", 16'h15, {11'h0, stateRed, seenCode});
    chk("config", 16'h0, {15'h0, patValid});
    cfg = 1'b0;
    do_reset();
    chk("power cycle", 16'h0, {11'h0, stateRed, lamp});
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    do_reset();
    burst(1'b0, '{4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hd, 4'he}, SHALF, WARN);
    burst(1'b1, '{4'h3, 4'h5, 4'h9, 4'hb, 4'hc, 4'he, 4'hf}, PHALF, 300);
    t_reserved();
    t_serious();
    finish_test();
  end
  // watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    finish_test();
  end
endmodule
